// file: verilog/tamlb_limit_bank.sv
// limit and third-alarm mask register bank with channel comparison
`timescale 1ns/1ps
`include "tamlb_map.svh"
module tamlb_limit_bank
  import tamlb_pkg::*;
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // command-byte register port
  input  wire logic [7:0]               reg_cmd,
  input  wire logic                     reg_wr_en,
  input  wire logic [7:0]               reg_wr_data,
  input  wire logic                     reg_rd_en,
  output logic [7:0]                    reg_rd_data,
  output logic                          reg_rd_valid,
  // channel temperatures, whole degrees, sys_clk domain
  input  wire logic [7:0]               local_temp,
  input  wire logic [7:0]               remote1_temp,
  input  wire logic [7:0]               remote2_temp,
  input  wire logic [7:0]               remote3_temp,
  input  wire logic [7:0]               remote4_temp,
  input  wire logic [`TAMLB_HYST_W-1:0] hyst_deg,
  // channel events and alarm pin
  output tamlb_chan_vec_type            alarm1_event,
  output tamlb_chan_vec_type            alarm23_event,
  output logic                          third_crit_alarm_out_n
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [`TAMLB_MASK3_W-1:0] mask3_q;
  logic [`TAMLB_LOCAL_W-1:0] local_lim_q;
  logic [7:0]                r1_a1_q;
  logic [7:0]                r2_a1_q;
  logic [7:0]                r3_q;
  logic [7:0]                r4_q;
  logic [7:0]                r1_a23_q;
  logic [7:0]                r2_a23_q;
  tamlb_byte_type            wr_keep;
  tamlb_byte_type            rd_d;
  logic                      local_alarm_block;
  logic                      remote1_alarm_block;
  logic                      remote2_alarm_block;
  logic                      remote3_alarm_block;
  logic                      remote4_alarm_block;
  tamlb_chan_vec_type        block_vec;
  logic [`TAMLB_HYST_W-1:0]  hyst_eff;
  logic [7:0]                temp_arr   [`TAMLB_NCH];
  logic [7:0]                lim_a1_arr [`TAMLB_NCH];
  logic [7:0]                lim_a23_arr[`TAMLB_NCH];

  assign wr_keep = tamlb_wr_keep(reg_cmd);

  // mask register; only the five channel bits are stored
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mask3_q <= `TAMLB_RST_MASK3;
    else if (reg_wr_en && reg_cmd == `TAMLB_CMD_MASK3)
      mask3_q <= reg_wr_data[`TAMLB_MASK3_W-1:0];
  end

  // limit registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      local_lim_q <= `TAMLB_RST_LOCAL;
      r1_a1_q     <= `TAMLB_RST_R_A1;
      r2_a1_q     <= `TAMLB_RST_R_A1;
      r3_q        <= `TAMLB_RST_R_SHARED;
      r4_q        <= `TAMLB_RST_R_SHARED;
      r1_a23_q    <= `TAMLB_RST_R_A23;
      r2_a23_q    <= `TAMLB_RST_R_A23;
    end
    else if (reg_wr_en)
    begin
      case (reg_cmd)
        `TAMLB_CMD_LOCAL:  local_lim_q <= reg_wr_data[`TAMLB_LOCAL_W-1:0];
        `TAMLB_CMD_R1_A1:  r1_a1_q     <= reg_wr_data;
        `TAMLB_CMD_R2_A1:  r2_a1_q     <= reg_wr_data;
        `TAMLB_CMD_R3:     r3_q        <= reg_wr_data;
        `TAMLB_CMD_R4:     r4_q        <= reg_wr_data;
        `TAMLB_CMD_R1_A23: r1_a23_q    <= reg_wr_data;
        `TAMLB_CMD_R2_A23: r2_a23_q    <= reg_wr_data;
        default:           ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // a read in the same cycle as a write to the same byte sees the old value
  always_comb
  begin
    case (reg_cmd)
      `TAMLB_CMD_MASK3:  rd_d = {3'h0, mask3_q};
      `TAMLB_CMD_LOCAL:  rd_d = {1'h0, local_lim_q};
      `TAMLB_CMD_R1_A1:  rd_d = r1_a1_q;
      `TAMLB_CMD_R2_A1:  rd_d = r2_a1_q;
      `TAMLB_CMD_R3:     rd_d = r3_q;
      `TAMLB_CMD_R4:     rd_d = r4_q;
      `TAMLB_CMD_R1_A23: rd_d = r1_a23_q;
      `TAMLB_CMD_R2_A23: rd_d = r2_a23_q;
      default:           rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
        reg_rd_data <= rd_d & ((wr_keep == `TAMLB_KEEP_NONE) ? 8'h00 : 8'hff);
    end
  end

  // ------------------------------------------------------------
  // channel routing
  // ------------------------------------------------------------
  assign local_alarm_block   = mask3_q[`TAMLB_CH_LOCAL];
  assign remote1_alarm_block = mask3_q[`TAMLB_CH_R1];
  assign remote2_alarm_block = mask3_q[`TAMLB_CH_R2];
  assign remote3_alarm_block = mask3_q[`TAMLB_CH_R3];
  assign remote4_alarm_block = mask3_q[`TAMLB_CH_R4];
  assign block_vec = {remote4_alarm_block, remote3_alarm_block, remote2_alarm_block,
                      remote1_alarm_block, local_alarm_block};

  // hysteresis range tops out at 32 degrees
  assign hyst_eff = (hyst_deg > `TAMLB_HYST_MAX) ? `TAMLB_HYST_MAX : hyst_deg;

  always_comb
  begin
    temp_arr[`TAMLB_CH_LOCAL]    = local_temp;
    temp_arr[`TAMLB_CH_R1]       = remote1_temp;
    temp_arr[`TAMLB_CH_R2]       = remote2_temp;
    temp_arr[`TAMLB_CH_R3]       = remote3_temp;
    temp_arr[`TAMLB_CH_R4]       = remote4_temp;
    lim_a1_arr[`TAMLB_CH_LOCAL]  = {1'h0, local_lim_q};
    lim_a1_arr[`TAMLB_CH_R1]     = r1_a1_q;
    lim_a1_arr[`TAMLB_CH_R2]     = r2_a1_q;
    lim_a1_arr[`TAMLB_CH_R3]     = r3_q;
    lim_a1_arr[`TAMLB_CH_R4]     = r4_q;
    lim_a23_arr[`TAMLB_CH_LOCAL] = {1'h0, local_lim_q};
    lim_a23_arr[`TAMLB_CH_R1]    = r1_a23_q;
    lim_a23_arr[`TAMLB_CH_R2]    = r2_a23_q;
    lim_a23_arr[`TAMLB_CH_R3]    = r3_q;
    lim_a23_arr[`TAMLB_CH_R4]    = r4_q;
  end

  // shared-limit channels get two comparators on purpose: it keeps one
  // uniform structure at the cost of a few flops
  for (genvar ch = 0; ch < `TAMLB_NCH; ch++)
  begin : g_chan
    tamlb_chan_cmp u_cmp_a1 (
      .sys_clk (sys_clk),
      .rst     (rst),
      .temp    (temp_arr[ch]),
      .limit   (lim_a1_arr[ch]),
      .hyst    (hyst_eff),
      .event_q (alarm1_event[ch])
    );
    tamlb_chan_cmp u_cmp_a23 (
      .sys_clk (sys_clk),
      .rst     (rst),
      .temp    (temp_arr[ch]),
      .limit   (lim_a23_arr[ch]),
      .hyst    (hyst_eff),
      .event_q (alarm23_event[ch])
    );
  end

  tamlb_alarm_gate u_gate (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .events    (alarm23_event),
    .block     (block_vec),
    .alarm_n_q (third_crit_alarm_out_n)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_mask_reset: assert property (
    @(posedge sys_clk) disable iff (rst)
    $fell(rst) |-> mask3_q == `TAMLB_RST_MASK3)
    else $error("mask register reset value wrong");

  a_limits_reset: assert property (
    @(posedge sys_clk) disable iff (rst)
    $fell(rst) |-> local_lim_q == `TAMLB_RST_LOCAL && r1_a1_q == `TAMLB_RST_R_A1
      && r2_a1_q == `TAMLB_RST_R_A1 && r3_q == `TAMLB_RST_R_SHARED
      && r4_q == `TAMLB_RST_R_SHARED && r1_a23_q == `TAMLB_RST_R_A23
      && r2_a23_q == `TAMLB_RST_R_A23)
    else $error("limit register reset value wrong");

  a_mask_resv_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd_en && reg_cmd == `TAMLB_CMD_MASK3 |=> reg_rd_valid && reg_rd_data[7:5] == 3'h0)
    else $error("mask reserved bits read nonzero");

  a_local_msb_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd_en && reg_cmd == `TAMLB_CMD_LOCAL |=> reg_rd_valid && !reg_rd_data[7])
    else $error("local limit bit 7 read nonzero");

  // a host leaves at least one idle cycle between a write and its readback
  a_resv_write_drop: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_wr_en && reg_cmd == `TAMLB_CMD_LOCAL ##1 !reg_wr_en
      ##1 reg_rd_en && !reg_wr_en && reg_cmd == `TAMLB_CMD_LOCAL
      |=> reg_rd_data == ($past(reg_wr_data, 3) & `TAMLB_KEEP_LOCAL))
    else $error("local limit write did not keep low seven bits");

  a_remote_readback: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_wr_en && reg_cmd == `TAMLB_CMD_R3 ##1 !reg_wr_en
      ##1 reg_rd_en && !reg_wr_en && reg_cmd == `TAMLB_CMD_R3
      |=> reg_rd_data == $past(reg_wr_data, 3))
    else $error("remote limit readback mismatch");

  a_unmapped_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd_en && tamlb_wr_keep(reg_cmd) == `TAMLB_KEEP_NONE |=> reg_rd_data == 8'h00)
    else $error("unmapped command read nonzero");

  a_r4_blocked: assert property (
    @(posedge sys_clk) disable iff (rst)
    remote4_alarm_block && alarm23_event == 5'h10 |=> third_crit_alarm_out_n)
    else $error("masked remote four reached alarm");

  a_r3_blocked: assert property (
    @(posedge sys_clk) disable iff (rst)
    remote3_alarm_block && alarm23_event == 5'h08 |=> third_crit_alarm_out_n)
    else $error("masked remote three reached alarm");

  a_r2_passes: assert property (
    @(posedge sys_clk) disable iff (rst)
    !remote2_alarm_block && alarm23_event[`TAMLB_CH_R2] |=> !third_crit_alarm_out_n)
    else $error("unmasked remote two did not reach alarm");

  a_r1_passes: assert property (
    @(posedge sys_clk) disable iff (rst)
    !remote1_alarm_block && alarm23_event[`TAMLB_CH_R1] |=> !third_crit_alarm_out_n)
    else $error("unmasked remote one did not reach alarm");

  a_local_blocked: assert property (
    @(posedge sys_clk) disable iff (rst)
    local_alarm_block && alarm23_event == 5'h01 |=> third_crit_alarm_out_n)
    else $error("masked local channel reached alarm");

  a_r1_a1_limit: assert property (
    @(posedge sys_clk) disable iff (rst)
    remote1_temp > r1_a1_q |=> alarm1_event[`TAMLB_CH_R1])
    else $error("remote one first-alarm event missed");

  a_r2_a23_limit: assert property (
    @(posedge sys_clk) disable iff (rst)
    remote2_temp > r2_a23_q |=> alarm23_event[`TAMLB_CH_R2])
    else $error("remote two alarm two/three event missed");

  a_r2_a1_limit: assert property (
    @(posedge sys_clk) disable iff (rst)
    remote2_temp > r2_a1_q |=> alarm1_event[`TAMLB_CH_R2])
    else $error("remote two first-alarm event missed");

  a_r1_a23_limit: assert property (
    @(posedge sys_clk) disable iff (rst)
    remote1_temp > r1_a23_q |=> alarm23_event[`TAMLB_CH_R1])
    else $error("remote one alarm two/three event missed");

  a_shared_same: assert property (
    @(posedge sys_clk) disable iff (rst)
    alarm1_event[`TAMLB_CH_R3] == alarm23_event[`TAMLB_CH_R3]
      && alarm1_event[`TAMLB_CH_R4] == alarm23_event[`TAMLB_CH_R4])
    else $error("shared limit channels disagree");

endmodule : tamlb_limit_bank

// file: verilog/tamlb_map.svh
// register offsets, reset values, field widths and limits of the alarm limit bank
`ifndef TAMLB_MAP_SVH
`define TAMLB_MAP_SVH

// ------------------------------------------------------------
// command bytes
// ------------------------------------------------------------
`define TAMLB_CMD_MASK3      8'h0e
`define TAMLB_CMD_LOCAL      8'h40
`define TAMLB_CMD_R1_A1      8'h41
`define TAMLB_CMD_R2_A1      8'h42
`define TAMLB_CMD_R3         8'h43
`define TAMLB_CMD_R4         8'h44
`define TAMLB_CMD_R1_A23     8'h49
`define TAMLB_CMD_R2_A23     8'h4a

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TAMLB_RST_MASK3      5'h07
`define TAMLB_RST_LOCAL      7'h55
`define TAMLB_RST_R_A1       8'h6e
`define TAMLB_RST_R_SHARED   8'h55
`define TAMLB_RST_R_A23      8'h55
`define TAMLB_RST_ALARM_N    1'h1

// ------------------------------------------------------------
// field widths and masks
// ------------------------------------------------------------
`define TAMLB_MASK3_W        5
`define TAMLB_LOCAL_W        7
`define TAMLB_KEEP_MASK3     8'h1f
`define TAMLB_KEEP_LOCAL     8'h7f
`define TAMLB_KEEP_FULL      8'hff
`define TAMLB_KEEP_NONE      8'h00
`define TAMLB_HYST_W         6
`define TAMLB_HYST_MAX       6'h20

// ------------------------------------------------------------
// channel index, also the mask bit position
// ------------------------------------------------------------
`define TAMLB_CH_LOCAL       0
`define TAMLB_CH_R1          1
`define TAMLB_CH_R2          2
`define TAMLB_CH_R3          3
`define TAMLB_CH_R4          4
`define TAMLB_NCH            5

`endif

// file: verilog/tamlb_pkg.sv
// types and decode helpers of the alarm limit bank
`include "tamlb_map.svh"
package tamlb_pkg;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef logic [7:0]              tamlb_byte_type;
  typedef logic [`TAMLB_NCH-1:0]   tamlb_chan_vec_type;

  // ------------------------------------------------------------
  // writable bits for a command byte; zero marks an unmapped command
  // ------------------------------------------------------------
  function automatic tamlb_byte_type tamlb_wr_keep(input tamlb_byte_type cmd);
    tamlb_byte_type keep;
    keep = `TAMLB_KEEP_NONE;
    case (cmd)
      `TAMLB_CMD_MASK3: keep = `TAMLB_KEEP_MASK3;
      `TAMLB_CMD_LOCAL: keep = `TAMLB_KEEP_LOCAL;
      `TAMLB_CMD_R1_A1, `TAMLB_CMD_R2_A1, `TAMLB_CMD_R3, `TAMLB_CMD_R4,
      `TAMLB_CMD_R1_A23, `TAMLB_CMD_R2_A23: keep = `TAMLB_KEEP_FULL;
      default: keep = `TAMLB_KEEP_NONE;
    endcase
    return keep;
  endfunction : tamlb_wr_keep

endpackage : tamlb_pkg

// file: verilog/tamlb_chan_cmp.sv
// one channel limit comparison with hysteresis on falling temperature
`timescale 1ns/1ps
`include "tamlb_map.svh"
module tamlb_chan_cmp
  import tamlb_pkg::*;
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // comparison inputs
  input  wire logic [7:0]               temp,
  input  wire logic [7:0]               limit,
  input  wire logic [`TAMLB_HYST_W-1:0] hyst,
  // error event
  output logic                          event_q
);

  logic over;
  logic under;

  // ------------------------------------------------------------
  // compare
  // ------------------------------------------------------------
  // adding hysteresis to temp avoids an underflow of limit - hyst
  always_comb
  begin
    over  = temp > limit;
    under = (9'({1'b0, temp}) + 9'(hyst)) <= 9'({1'b0, limit});
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      event_q <= 1'b0;
    else if (over)
      event_q <= 1'b1;
    else if (under)
      event_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_event_rises: assert property (
    @(posedge sys_clk) disable iff (rst)
    temp > limit |=> event_q)
    else $error("event not raised above limit");

  a_hyst_holds: assert property (
    @(posedge sys_clk) disable iff (rst)
    event_q && (9'({1'b0, temp}) + 9'(hyst)) > 9'({1'b0, limit}) |=> event_q)
    else $error("event dropped inside hysteresis band");

  a_event_clears: assert property (
    @(posedge sys_clk) disable iff (rst)
    (9'({1'b0, temp}) + 9'(hyst)) <= 9'({1'b0, limit}) |=> !event_q)
    else $error("event kept below hysteresis point");

endmodule : tamlb_chan_cmp

// file: verilog/tamlb_alarm_gate.sv
// mask gating of channel events onto the active-low third alarm pin
`timescale 1ns/1ps
`include "tamlb_map.svh"
module tamlb_alarm_gate
  import tamlb_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // events and block bits
  input  wire tamlb_chan_vec_type  events,
  input  wire tamlb_chan_vec_type  block,
  // alarm pin, low while active
  output logic                     alarm_n_q
);

  // ------------------------------------------------------------
  // gate
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      alarm_n_q <= `TAMLB_RST_ALARM_N;
    else
      alarm_n_q <= ~|(events & ~block);
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_gate_passes: assert property (
    @(posedge sys_clk) disable iff (rst)
    |(events & ~block) |=> !alarm_n_q)
    else $error("unmasked event did not assert alarm");

  a_gate_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    (events & ~block) == '0 |=> alarm_n_q)
    else $error("alarm active with no unmasked event");

endmodule : tamlb_alarm_gate

// file: tb/tamlb_host_model.sv
// host-side model issuing command-byte register accesses
`timescale 1ns/1ps
module tamlb_host_model
(
  // clock
  input  wire logic       sys_clk,
  // register port requests
  output logic      [7:0] reg_cmd,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_data,
  output logic            reg_rd_en
);
  initial
  begin
    reg_cmd     = 8'h00;
    reg_wr_en   = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en   = 1'b0;
  end

  // idle lines carry the inverse so a stale value never passes for a request
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(posedge sys_clk);
    reg_cmd     <= cmd;
    reg_wr_data <= data;
    reg_wr_en   <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en   <= 1'b0;
    reg_cmd     <= ~cmd;
    reg_wr_data <= ~data;
  endtask : wr

  // gap idles the host first, to mix prompt and slow accesses
  task automatic rd(input logic [7:0] cmd, input int gap);
    repeat (gap + 1) @(posedge sys_clk);
    reg_cmd   <= cmd;
    reg_rd_en <= 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    reg_cmd   <= ~cmd;
  endtask : rd
endmodule : tamlb_host_model

// file: tb/temp_alarm_mask_limit_bank_bench.sv
// self-checking bench of the alarm limit bank
`timescale 1ns/1ps
`include "tamlb_map.svh"
module temp_alarm_mask_limit_bank_bench
  import tamlb_pkg::*;
;
  logic               sys_clk;
  logic               rst;
  logic [7:0]         reg_cmd;
  logic               reg_wr_en;
  logic [7:0]         reg_wr_data;
  logic               reg_rd_en;
  logic [7:0]         reg_rd_data;
  logic               reg_rd_valid;
  logic [7:0]         ch_temp [5];
  logic [5:0]         hyst_deg;
  tamlb_chan_vec_type alarm1_event;
  tamlb_chan_vec_type alarm23_event;
  logic               third_crit_alarm_out_n;
  logic [7:0]         exp_q [$];
  logic [31:0]        lfsr;
  int                 n_fail;
  int                 check_count;

  localparam logic [7:0] cmd_tab [8] = '{8'h0e, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h49, 8'h4a};
  localparam logic [7:0] rst_tab [8] = '{8'h07, 8'h55, 8'h6e, 8'h6e, 8'h55, 8'h55, 8'h55, 8'h55};
  localparam logic [7:0] keep_tab [8] = '{8'h1f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] lim_tab [8] = '{8'h1f, 8'h30, 8'hf0, 8'hf0, 8'h30, 8'h30, 8'h30, 8'h30};
  localparam logic [7:0] hs_temp [7] = '{8'h30, 8'h50, 8'h2c, 8'h26, 8'h50, 8'h11, 8'h10};
  localparam logic [5:0] hs_hyst [7] = '{6'h00, 6'h0a, 6'h0a, 6'h0a, 6'h3f, 6'h3f, 6'h3f};
  localparam logic       hs_ev [7] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  tamlb_host_model u_tamlb_host_model (
    .sys_clk     (sys_clk),
    .reg_cmd     (reg_cmd),
    .reg_wr_en   (reg_wr_en),
    .reg_wr_data (reg_wr_data),
    .reg_rd_en   (reg_rd_en)
  );

  tamlb_limit_bank u_tamlb_limit_bank (
    .sys_clk                (sys_clk),
    .rst                    (rst),
    .reg_cmd                (reg_cmd),
    .reg_wr_en              (reg_wr_en),
    .reg_wr_data            (reg_wr_data),
    .reg_rd_en              (reg_rd_en),
    .reg_rd_data            (reg_rd_data),
    .reg_rd_valid           (reg_rd_valid),
    .local_temp             (ch_temp[0]),
    .remote1_temp           (ch_temp[1]),
    .remote2_temp           (ch_temp[2]),
    .remote3_temp           (ch_temp[3]),
    .remote4_temp           (ch_temp[4]),
    .hyst_deg               (hyst_deg),
    .alarm1_event           (alarm1_event),
    .alarm23_event          (alarm23_event),
    .third_crit_alarm_out_n (third_crit_alarm_out_n)
  );

  // ------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: pin %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // read data is taken while valid stands, half a cycle after it settles
  always @(negedge sys_clk)
  begin
    if (reg_rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check_val(reg_rd_data, ~reg_rd_data);
      else
        check_val(reg_rd_data, exp_q.pop_front());
    end
  end

  task automatic read_exp(input logic [7:0] cmd, input logic [7:0] exp);
    exp_q.push_back(exp);
    lfsr = lfsr_next(lfsr);
    u_tamlb_host_model.rd(cmd, int'(lfsr[1:0]));
  endtask : read_exp

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_n

  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask : do_reset

  task automatic check_reset_values();
    for (int i = 0; i < 8; i++)
      read_exp(cmd_tab[i], rst_tab[i]);
    read_exp(8'h0f, 8'h00);
    wait_n(3);
    check_val(8'(exp_q.size()), 8'h00);
  endtask : check_reset_values

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    hyst_deg = 6'h00;
    lfsr = 32'hf97c;
    n_fail = 0;
    check_count = 0;
    foreach (ch_temp[c]) ch_temp[c] = 8'h20;
    do_reset();
    check_reset_values();
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
      u_tamlb_host_model.wr(cmd_tab[i], 8'hff);
    u_tamlb_host_model.wr(8'h0f, 8'h5a);
    for (int i = 0; i < 8; i++)
      read_exp(cmd_tab[i], keep_tab[i]);
    read_exp(8'h0f, 8'h00);
    for (int k = 0; k < 16; k++)
    begin
      lfsr = lfsr_next(lfsr);
      u_tamlb_host_model.wr(cmd_tab[2 + lfsr[4:2] % 6], lfsr[15:8]);
      read_exp(cmd_tab[2 + lfsr[4:2] % 6], lfsr[15:8]);
    end
    // prompt readback, the closest a read may follow a write
    u_tamlb_host_model.wr(8'h43, 8'h9c);
    exp_q.push_back(8'h9c);
    u_tamlb_host_model.rd(8'h43, 0);
    u_tamlb_host_model.wr(8'h40, 8'hd5);
    exp_q.push_back(8'h55);
    u_tamlb_host_model.rd(8'h40, 0);
    wait_n(3);
    $display("test write and readback done");
    do_reset();
    check_reset_values();
    $display("test second reset done");
    // all channels masked first, so the pin must stay idle until one is opened
    for (int i = 0; i < 8; i++)
      u_tamlb_host_model.wr(cmd_tab[i], lim_tab[i]);
    for (int c = 0; c < 5; c++)
    begin
      ch_temp[c] <= 8'h50;
      wait_n(3);
      check_val({3'h0, alarm23_event}, 8'h01 << c);
      check_val({3'h0, alarm1_event}, (c == 1 || c == 2) ? 8'h00 : 8'h01 << c);
      check_bit(third_crit_alarm_out_n, 1'b1);
      u_tamlb_host_model.wr(8'h0e, 8'h1f & ~(8'h01 << c));
      wait_n(2);
      check_bit(third_crit_alarm_out_n, 1'b0);
      u_tamlb_host_model.wr(8'h0e, 8'h1f);
      ch_temp[c] <= 8'h20;
      wait_n(3);
      check_val({3'h0, alarm23_event}, 8'h00);
      check_bit(third_crit_alarm_out_n, 1'b1);
    end
    $display("test mask gating done");
    u_tamlb_host_model.wr(8'h0e, 8'h17);
    for (int s = 0; s < 7; s++)
    begin
      @(posedge sys_clk);
      ch_temp[3] <= hs_temp[s];
      hyst_deg <= hs_hyst[s];
      wait_n(3);
      check_val({7'h00, alarm23_event[3]}, {7'h00, hs_ev[s]});
      check_bit(third_crit_alarm_out_n, ~hs_ev[s]);
    end
    $display("test hysteresis done");
    complete_run();
  end

  // the whole sequence needs well under two thousand cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
endmodule : temp_alarm_mask_limit_bank_bench
